// ### core/drrr_reply_regs.v
/*
 * reply words a motor drive returns to the network master:
 * monitor words, reply codes, read data, fault records
 * and extended instruction replies.
 * assumes master words and triggers come from link logic on clk,
 * and that the drive answers lookups on the same clock.
 */
`timescale 1ns/1ps
`include "drrr_consts.vh"

module drrr_reply_regs (
	// clock, reset, enable
	input  wire         clk,
	input  wire         reset_n,
	input  wire         ce,
	// trigger bits from the master
	input  wire         monitor_trigger_bit,
	input  wire         frequency_write_trigger_volatile,
	input  wire         frequency_write_trigger_persistent,
	input  wire         instruction_execute_trigger,
	// master words
	input  wire [15:0]  monitor_select_word,
	input  wire [15:0]  third_monitor_select_word,
	input  wire [15:0]  fourth_monitor_select_word,
	input  wire [15:0]  fifth_monitor_select_word,
	input  wire [15:0]  sixth_monitor_select_word,
	input  wire [15:0]  frequency_command_word,
	input  wire [15:0]  first_instruction_word,
	input  wire [15:0]  first_instruction_data,
	input  wire [79:0]  extended_instruction_words,
	input  wire [79:0]  extended_instruction_data,
	input  wire [15:0]  fault_record_select_word,
	// settings
	input  wire [7:0]   cyclic_profile_setting,
	input  wire         negative_monitor_display_setting,
	// drive state
	input  wire [15:0]  output_frequency,
	input  wire         drive_stopped,
	input  wire         network_mode,
	// monitor item lookup
	output reg  [7:0]   mon_item_code,
	input  wire [15:0]  mon_item_value,
	// fault history lookup
	output wire [7:0]   fault_record_no,
	input  wire [7:0]   fault_code_in,
	input  wire [15:0]  fault_frequency_in,
	input  wire [15:0]  fault_current_in,
	input  wire [15:0]  fault_voltage_in,
	input  wire [15:0]  fault_on_time_in,
	// frequency write path to the drive
	output reg          freq_wr_req,
	output reg          freq_wr_persistent,
	output reg  [15:0]  freq_wr_value,
	input  wire         freq_wr_done,
	input  wire [7:0]   freq_wr_reply,
	// instruction path to the drive
	output reg          instr_req,
	output reg  [15:0]  instr_code,
	output reg  [15:0]  instr_data,
	input  wire         instr_done,
	input  wire [7:0]   instr_reply,
	input  wire [15:0]  instr_read_data,
	// reply words to the master
	output reg  [15:0]  first_monitor_word,
	output reg  [15:0]  second_monitor_or_frequency_word,
	output reg  [15:0]  command_reply_word,
	output reg  [15:0]  instruction_read_data_word,
	output reg  [15:0]  third_monitor_word,
	output reg  [15:0]  fourth_monitor_word,
	output reg  [15:0]  fifth_monitor_word,
	output reg  [15:0]  sixth_monitor_word,
	output reg  [15:0]  fault_record_data_word,
	output reg  [15:0]  fault_record_frequency_word,
	output reg  [15:0]  fault_record_current_word,
	output reg  [15:0]  fault_record_voltage_word,
	output reg  [15:0]  fault_record_on_time_word,
	output wire [159:0] extended_reply_and_data_words,
	output reg          instruction_complete_flag
);

	// --------------------
	// instruction sequencer states
	// --------------------
	localparam S_IDLE  = 3'h0;
	localparam S_ISSUE = 3'h1;
	localparam S_WAIT  = 3'h2;
	localparam S_NEXT  = 3'h3;
	localparam S_DONE  = 3'h4;

	reg  [2:0]  state;
	reg  [2:0]  slot;
	reg  [2:0]  mon_slot;
	reg         freq_busy;
	reg  [15:0] ext_word [0:`DRRR_EXT_WORDS-1];

	wire [2:0]  trig_rise;
	wire [15:0] mon_shown;
	wire        combined = (cyclic_profile_setting == `DRRR_PROFILE_COMBINED);
	wire        hi_sel   = (monitor_select_word[15:8] != `DRRR_HIGH_BYTE_NONE);

	// --------------------
	// trigger edges
	// --------------------
	// an operation starts on the rise, so a trigger held high runs once
	drrr_rise #(
		.W (3)
	) u_rise (
		.clk     (clk),
		.reset_n (reset_n),
		.ce      (ce),
		.level   ({instruction_execute_trigger,
		           frequency_write_trigger_persistent,
		           frequency_write_trigger_volatile}),
		.rise    (trig_rise)
	);

	wire freq_rise = trig_rise[0] | trig_rise[1];
	wire exec_rise = trig_rise[2];

	// --------------------
	// monitor scan
	// --------------------
	// one lookup port is shared: slots are visited one per cycle
	always @* begin
		case (mon_slot)
			3'h0: mon_item_code = monitor_select_word[7:0];
			3'h1: mon_item_code = monitor_select_word[15:8];
			3'h2: mon_item_code = third_monitor_select_word[7:0];
			3'h3: mon_item_code = fourth_monitor_select_word[7:0];
			3'h4: mon_item_code = fifth_monitor_select_word[7:0];
			default: mon_item_code = sixth_monitor_select_word[7:0];
		endcase
	end

	drrr_mon_format u_fmt (
		.raw        (mon_item_value),
		.neg_enable (negative_monitor_display_setting),
		.shown      (mon_shown)
	);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mon_slot                         <= 3'h0;
			first_monitor_word               <= `DRRR_WORD_RESET;
			second_monitor_or_frequency_word <= `DRRR_WORD_RESET;
			third_monitor_word               <= `DRRR_WORD_RESET;
			fourth_monitor_word              <= `DRRR_WORD_RESET;
			fifth_monitor_word               <= `DRRR_WORD_RESET;
			sixth_monitor_word               <= `DRRR_WORD_RESET;
		end else if (ce) begin
			if (monitor_trigger_bit) begin
				if (mon_slot == `DRRR_LAST_MON_SLOT) begin
					mon_slot <= 3'h0;
				end else begin
					mon_slot <= mon_slot + 3'h1;
				end
				case (mon_slot)
					3'h0: first_monitor_word <= mon_shown; // [R1]
					3'h1: begin
						if (hi_sel) begin
							second_monitor_or_frequency_word <= mon_shown; // [R3]
						end
					end
					3'h2: third_monitor_word <= mon_shown; // [R9]
					3'h3: fourth_monitor_word <= mon_shown; // [R9]
					3'h4: fifth_monitor_word <= mon_shown; // [R9]
					default: sixth_monitor_word <= mon_shown; // [R9]
				endcase
			end else begin
				mon_slot <= 3'h0;
			end
			// raw frequency units; speed display scaling never applies here
			if (!hi_sel) begin
				second_monitor_or_frequency_word <= output_frequency; // [R2] [R15]
			end
		end
	end

	// --------------------
	// fault record words
	// --------------------
	assign fault_record_no = fault_record_select_word[7:0];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_record_data_word      <= `DRRR_WORD_RESET;
			fault_record_frequency_word <= `DRRR_WORD_RESET;
			fault_record_current_word   <= `DRRR_WORD_RESET;
			fault_record_voltage_word   <= `DRRR_WORD_RESET;
			fault_record_on_time_word   <= `DRRR_WORD_RESET;
		end else if (ce) begin
			fault_record_data_word      <= {fault_record_select_word[7:0], fault_code_in}; // [R10]
			fault_record_frequency_word <= fault_frequency_in; // [R11]
			fault_record_current_word   <= fault_current_in; // [R12]
			fault_record_voltage_word   <= fault_voltage_in; // [R12]
			fault_record_on_time_word   <= fault_on_time_in; // [R12]
		end
	end

	// --------------------
	// instruction selection
	// --------------------
	wire [2:0]  ext_slot = slot - 3'h1;
	wire [6:0]  ext_base = {ext_slot, 4'h0};
	wire [3:0]  ext_idx  = {ext_slot, 1'b0};
	wire [15:0] cur_code = (slot == 3'h0) ? first_instruction_word
	                                      : extended_instruction_words[ext_base +: 16];
	wire [15:0] cur_data = (slot == 3'h0) ? first_instruction_data
	                                      : extended_instruction_data[ext_base +: 16];

	// only extended instructions may be disabled; the first is never skipped as disabled
	wire cur_skip    = (slot != 3'h0) && (cur_code == `DRRR_INSTR_DISABLED); // [R18]
	// a write while running under network control is refused here
	wire cur_blocked = cur_code[`DRRR_INSTR_WRITE_BIT] & network_mode & ~drive_stopped; // [R17]

	wire store_en = ((state == S_ISSUE) && !cur_skip && cur_blocked) ||
	                ((state == S_WAIT) && instr_done);
	wire [7:0]  store_code = (state == S_WAIT) ? instr_reply : `DRRR_REPLY_WRITE_MODE; // [R5]
	wire        store_ok   = (store_code == `DRRR_REPLY_OK);
	wire [15:0] store_data = store_ok ? instr_read_data : `DRRR_WORD_RESET; // [R8]
	wire        first_done = store_en && (slot == 3'h0);
	wire        freq_done  = freq_busy && freq_wr_done;

	// --------------------
	// instruction sequencer and frequency write
	// --------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state                     <= S_IDLE;
			slot                      <= 3'h0;
			instr_req                 <= 1'b0;
			instr_code                <= `DRRR_WORD_RESET;
			instr_data                <= `DRRR_WORD_RESET;
			instruction_complete_flag <= 1'b0;
			freq_busy                 <= 1'b0;
			freq_wr_req               <= 1'b0;
			freq_wr_persistent        <= 1'b0;
			freq_wr_value             <= `DRRR_WORD_RESET;
		end else if (ce) begin
			instr_req   <= 1'b0;
			freq_wr_req <= 1'b0;
			// a new frequency trigger while one is pending is ignored
			if (freq_rise && !freq_busy) begin
				freq_busy          <= 1'b1;
				freq_wr_req        <= 1'b1;
				freq_wr_persistent <= trig_rise[1];
				freq_wr_value      <= frequency_command_word;
			end else if (freq_done) begin
				freq_busy <= 1'b0;
			end
			case (state)
				S_IDLE: begin
					if (exec_rise) begin
						slot                      <= 3'h0;
						instruction_complete_flag <= 1'b0;
						state                     <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					if (cur_skip || cur_blocked) begin
						state <= S_NEXT;
					end else begin
						instr_req  <= 1'b1;
						instr_code <= cur_code;
						instr_data <= cur_data;
						state      <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (instr_done) begin
						state <= S_NEXT;
					end
				end
				S_NEXT: begin
					if (slot == `DRRR_LAST_INSTR_SLOT) begin
						instruction_complete_flag <= 1'b1; // [R18]
						state                     <= S_DONE;
					end else begin
						slot  <= slot + 3'h1; // [R18]
						state <= S_ISSUE;
					end
				end
				S_DONE: begin
					// flag stays up until the master drops the execute trigger
					if (!instruction_execute_trigger) begin
						instruction_complete_flag <= 1'b0;
						state                     <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// --------------------
	// reply and read data words
	// --------------------
	// words change only on a completion, so the master may read late
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			command_reply_word         <= `DRRR_WORD_RESET;
			instruction_read_data_word <= `DRRR_WORD_RESET;
		end else if (ce) begin
			if (combined) begin
				// the instruction reply wins a tie with the frequency reply
				if (first_done) begin
					command_reply_word <= {8'h00, store_code}; // [R4] [R19]
				end else if (freq_done) begin
					command_reply_word <= {8'h00, freq_wr_reply}; // [R4] [R14]
				end
			end else begin
				if (first_done) begin
					command_reply_word[15:8] <= store_code; // [R7]
				end
				if (freq_done) begin
					command_reply_word[7:0] <= freq_wr_reply; // [R6]
				end
			end
			if (first_done) begin
				instruction_read_data_word <= store_data; // [R8] [R19]
			end
		end
	end

	// --------------------
	// extended reply words
	// --------------------
	integer k;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (k = 0; k < `DRRR_EXT_WORDS; k = k + 1) begin
				ext_word[k] <= `DRRR_WORD_RESET;
			end
		end else if (ce) begin
			if (store_en && (slot != 3'h0)) begin
				ext_word[ext_idx]        <= {8'h00, store_code}; // [R13]
				ext_word[ext_idx + 4'h1] <= store_data; // [R13] [R8]
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `DRRR_EXT_WORDS; g = g + 1) begin : g_ext
			assign extended_reply_and_data_words[g*16 +: 16] = ext_word[g];
		end
	endgenerate

endmodule

// ### core/drrr_consts.vh
/*
 * drive reply block constants.
 * assumes inclusion by bare name.
 */
`ifndef DRRR_CONSTS_VH
`define DRRR_CONSTS_VH

// Overview of operation
// [R1] monitor trigger high: first monitor word gets item chosen by select low byte
// [R2] select high byte zero: second monitor word shows present output frequency
// [R3] monitor trigger high, high byte nonzero: second word gets that item
// [R4] combined mode: frequency reply on write trigger, first instruction reply on execute
// [R5] reply codes are zero on success, nonzero on any error
// [R6] split mode: frequency/torque write reply goes to reply word low byte
// [R7] split mode: first instruction reply goes to reply word high byte
// [R8] after success the instruction's returned value fills the following read data word
// [R9] monitor trigger high: third to sixth words get items of matching select words
// [R10] fault data word: record data low byte, echoed record number high byte
// [R11] fault record frequency word in frequency units, speed scaling ignored
// [R12] fault current, voltage and on-time words are refreshed continuously
// [R13] execute trigger: extended words get reply and read data per extended instruction
// [R14] master reads the reply word after a trigger before relying on the result
// [R15] frequency monitor items ignore speed display rescaling
// [R16] negative monitor values shown signed only when enabled, else magnitudes
// [R17] reply codes: 0 normal, 1 write mode, 2 unregistered code, 3 out of range
// [R18] instructions run in ascending order, disabled skipped, then completion flag set
// [R19] reply and read data words hold until the next matching trigger

// --------------------
// reply codes
// --------------------
`define DRRR_REPLY_OK          8'h00
`define DRRR_REPLY_WRITE_MODE  8'h01
`define DRRR_REPLY_BAD_CODE    8'h02
`define DRRR_REPLY_RANGE       8'h03

// --------------------
// instruction and mode encodings
// --------------------
`define DRRR_INSTR_DISABLED    16'hffff
`define DRRR_INSTR_WRITE_BIT   7
`define DRRR_PROFILE_COMBINED  8'h00
`define DRRR_HIGH_BYTE_NONE    8'h00

// --------------------
// slot counts and reset values
// --------------------
`define DRRR_LAST_MON_SLOT     3'h5
`define DRRR_LAST_INSTR_SLOT   3'h5
`define DRRR_EXT_WORDS         10
`define DRRR_WORD_RESET        16'h0000

`endif

// ### core/drrr_mon_format.v
/*
 * sign handling of one monitor value.
 * assumes the raw value arrives as two's complement from the drive.
 */
`timescale 1ns/1ps
`include "drrr_consts.vh"

module drrr_mon_format (
	// value from the drive
	input  wire [15:0] raw,
	// setting
	input  wire        neg_enable,
	// value as shown
	output wire [15:0] shown
);

	// --------------------
	// magnitude unless negatives enabled
	// --------------------
	// the most negative value has no positive twin; it shows as 16'h8000
	wire [15:0] magnitude = raw[15] ? (16'h0000 - raw) : raw;

	assign shown = neg_enable ? raw : magnitude; // [R16]

endmodule

// ### core/drrr_rise.v
/*
 * rising edge detector, one flip-flop per bit.
 * assumes inputs come from logic on the same clock, so no synchroniser.
 */
`timescale 1ns/1ps

module drrr_rise #(
	parameter W = 4
) (
	// clock, reset, enable
	input  wire         clk,
	input  wire         reset_n,
	input  wire         ce,
	// levels and their edges
	input  wire [W-1:0] level,
	output wire [W-1:0] rise
);

	reg [W-1:0] prev;

	// --------------------
	// per bit edge
	// --------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					prev[i] <= 1'b0;
				end else if (ce) begin
					prev[i] <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev[i];
		end
	endgenerate

endmodule

// ### tb/drrr_drive_model.sv
/*
 * drive model: monitor items, fault history, command answers.
 * assumes one-cycle request pulses; slow stretches answers to five cycles.
 */
`timescale 1ns/1ps

module drrr_drive_model (
	// clock and pacing
	input  wire         clk,
	input  wire         reset_n,
	input  wire         slow,
	// lookups
	input  wire  [7:0]  mon_item_code,
	output logic [15:0] mon_item_value,
	input  wire  [7:0]  fault_record_no,
	output logic [7:0]  fault_code_in,
	output logic [15:0] fault_frequency_in,
	output logic [15:0] fault_current_in,
	output logic [15:0] fault_voltage_in,
	output logic [15:0] fault_on_time_in,
	// frequency writes
	input  wire         freq_wr_req,
	input  wire  [15:0] freq_wr_value,
	output logic        freq_wr_done,
	output logic [7:0]  freq_wr_reply,
	// instructions
	input  wire         instr_req,
	input  wire  [15:0] instr_code,
	input  wire  [15:0] instr_data,
	output logic        instr_done,
	output logic [7:0]  instr_reply,
	output logic [15:0] instr_read_data
);
	logic [2:0]  fcnt;
	logic [2:0]  icnt;
	logic        fbad;
	logic        ibad;
	logic [15:0] ird;

	// bit 7 codes read negative
	always_comb begin
		mon_item_value     = mon_item_code[7] ? 16'h0000 - {8'h00, mon_item_code} : {8'h00, mon_item_code};
		fault_code_in      = fault_record_no ^ 8'h5a;
		fault_frequency_in = {fault_record_no, 8'h11};
		fault_current_in   = {fault_record_no, 8'h22};
		fault_voltage_in   = {fault_record_no, 8'h33};
		fault_on_time_in   = {8'h44, fault_record_no};
	end

	// answers toggle when not done, so stale values fail
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{fcnt, icnt, fbad, ibad, ird} <= '0;
			{freq_wr_done, instr_done, freq_wr_reply, instr_reply, instr_read_data} <= '0;
		end else begin
			if (freq_wr_req) begin
				fcnt <= slow ? 3'h5 : 3'h1;
				fbad <= freq_wr_value[15];
			end else if (fcnt != 3'h0) begin
				fcnt <= fcnt - 3'h1;
			end
			if (instr_req) begin
				icnt <= slow ? 3'h5 : 3'h1;
				ibad <= (instr_code[15:8] == 8'h0f);
				ird  <= instr_data ^ instr_code;
			end else if (icnt != 3'h0) begin
				icnt <= icnt - 3'h1;
			end
			freq_wr_done    <= (fcnt == 3'h1) && !freq_wr_req;
			freq_wr_reply   <= (fcnt == 3'h1) ? (fbad ? 8'h03 : 8'h00) : ~freq_wr_reply;
			instr_done      <= (icnt == 3'h1) && !instr_req;
			instr_reply     <= (icnt == 3'h1) ? (ibad ? 8'h02 : 8'h00) : ~instr_reply;
			instr_read_data <= (icnt == 3'h1) ? ird : ~instr_read_data;
		end
	end
endmodule

// ### tb/drrr_reply_regs_checker.sv
/*
 * concurrent checks on the ports of the reply register block.
 * assumes ce held high.
 */
`timescale 1ns/1ps

module drrr_reply_regs_checker (
	// clock and reset
	input wire        clk,
	input wire        reset_n,
	// watched ports
	input wire        monitor_trigger_bit,
	input wire        instruction_execute_trigger,
	input wire [15:0] monitor_select_word,
	input wire [15:0] fault_record_select_word,
	input wire [7:0]  cyclic_profile_setting,
	input wire        negative_monitor_display_setting,
	input wire [15:0] output_frequency,
	input wire [7:0]  mon_item_code,
	input wire [15:0] mon_item_value,
	input wire [7:0]  fault_code_in,
	input wire [15:0] fault_frequency_in,
	input wire [15:0] fault_current_in,
	input wire        freq_wr_done,
	input wire [7:0]  freq_wr_reply,
	input wire        instr_req,
	input wire        instr_done,
	input wire [15:0] first_monitor_word,
	input wire [15:0] second_monitor_or_frequency_word,
	input wire [15:0] command_reply_word,
	input wire [15:0] fault_record_data_word,
	input wire [15:0] fault_record_frequency_word,
	input wire [15:0] fault_record_current_word,
	input wire        instruction_complete_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_mon_first;
		$rose(monitor_trigger_bit) && (negative_monitor_display_setting || !mon_item_value[15])
		|-> mon_item_code == monitor_select_word[7:0] ##1 first_monitor_word == $past(mon_item_value);
	endproperty
	a_mon_first: assert property (p_mon_first) else $error("first monitor word wrong");
	property p_freq_word;
		monitor_select_word[15:8] == 8'h00 && !output_frequency[15]
		|=> second_monitor_or_frequency_word == $past(output_frequency);
	endproperty
	a_freq_word: assert property (p_freq_word) else $error("second word wrong");
	property p_fault_data;
		1'b1 |=> fault_record_data_word == {$past(fault_record_select_word[7:0]), $past(fault_code_in)};
	endproperty
	a_fault_data: assert property (p_fault_data) else $error("fault data word wrong");
	property p_fault_freq;
		1'b1 |=> fault_record_frequency_word == $past(fault_frequency_in);
	endproperty
	a_fault_freq: assert property (p_fault_freq) else $error("fault frequency word wrong");
	property p_fault_cur;
		1'b1 |=> fault_record_current_word == $past(fault_current_in);
	endproperty
	a_fault_cur: assert property (p_fault_cur) else $error("fault current word wrong");
	property p_reply_comb;
		freq_wr_done && cyclic_profile_setting == 8'h00 && !instr_done
		|=> command_reply_word == {8'h00, $past(freq_wr_reply)};
	endproperty
	a_reply_comb: assert property (p_reply_comb) else $error("combined reply wrong");
	property p_reply_split;
		freq_wr_done && cyclic_profile_setting != 8'h00 |=> command_reply_word[7:0] == $past(freq_wr_reply);
	endproperty
	a_reply_split: assert property (p_reply_split) else $error("split low reply wrong");
	property p_hold;
		!freq_wr_done && !instr_done && !instruction_execute_trigger |=> $stable(command_reply_word);
	endproperty
	a_hold: assert property (p_hold) else $error("reply word changed");
	property p_flag_clear;
		instruction_complete_flag && !instruction_execute_trigger |=> !instruction_complete_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("complete flag not cleared");
	property p_flag_idle;
		instruction_complete_flag |-> !instr_req;
	endproperty
	a_flag_idle: assert property (p_flag_idle) else $error("request after completion");
endmodule

bind drrr_reply_regs drrr_reply_regs_checker u_chk (.*);

// ### tb/drrr_reply_regs_tb.sv
/*
 * bench for the reply register block with a drive model.
 * assumes ce held high throughout.
 */
`timescale 1ns/1ps
`include "drrr_consts.vh"

module drrr_reply_regs_tb;
	typedef struct {logic [7:0] prof; logic pers; logic [15:0] val; logic [15:0] exp; logic [15:0] mask;} drrr_row_t;

	logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, slow = 1'b0;
	logic monitor_trigger_bit = 0, frequency_write_trigger_volatile = 0;
	logic frequency_write_trigger_persistent = 0, instruction_execute_trigger = 0;
	logic [15:0] monitor_select_word = 0, third_monitor_select_word = 0, fourth_monitor_select_word = 0;
	logic [15:0] fifth_monitor_select_word = 0, sixth_monitor_select_word = 0, frequency_command_word = 0;
	logic [15:0] first_instruction_word = 0, first_instruction_data = 0, fault_record_select_word = 0;
	logic [79:0] extended_instruction_words = 0, extended_instruction_data = 0;
	logic [7:0]  cyclic_profile_setting = 0;
	logic        negative_monitor_display_setting = 0, drive_stopped = 1, network_mode = 0;
	logic [15:0] output_frequency = 0;
	wire  [7:0]  mon_item_code, fault_record_no, fault_code_in, freq_wr_reply, instr_reply;
	wire  [15:0] mon_item_value, fault_frequency_in, fault_current_in, fault_voltage_in, fault_on_time_in;
	wire  [15:0] freq_wr_value, instr_code, instr_data, instr_read_data;
	wire         freq_wr_req, freq_wr_persistent, freq_wr_done, instr_req, instr_done, instruction_complete_flag;
	wire  [15:0] first_monitor_word, second_monitor_or_frequency_word, command_reply_word;
	wire  [15:0] instruction_read_data_word, third_monitor_word, fourth_monitor_word, fifth_monitor_word;
	wire  [15:0] sixth_monitor_word, fault_record_data_word, fault_record_frequency_word;
	wire  [15:0] fault_record_current_word, fault_record_voltage_word, fault_record_on_time_word;
	wire  [159:0] extended_reply_and_data_words;
	int bad_count = 0, checks = 0, req_seen = 0, i;
	drrr_row_t rows [4] = '{'{8'h00, 0, 16'h1388, 16'h0000, 16'hffff}, '{8'h00, 1, 16'h9000, 16'h0003, 16'hffff},
		'{8'h0e, 0, 16'h7fff, 16'h0000, 16'h00ff}, '{8'h0e, 1, 16'h8000, 16'h0003, 16'h00ff}};
	logic [15:0] exp_ext [10] = '{16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001, 16'h0000,
		16'h0000, 16'h1134, 16'h0000, 16'h0401};

	drrr_reply_regs DUT (.*);
	drrr_drive_model u_drive (.*);

	always #5 clk = ~clk;
	always @(posedge clk) if (instr_req === 1'b1) req_seen++;

	// --------------------
	// helpers
	// --------------------
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] exp_mon(input logic [7:0] code, input logic neg);
		return (neg && code[7]) ? 16'h0000 - {8'h00, code} : {8'h00, code};
	endfunction
	task automatic report_and_stop;
		$display("bad_count=%0d checks=%0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#60000;
		bad_count++;
		report_and_stop;
	end

	// --------------------
	// main sequence
	// --------------------
	initial begin
		monitor_select_word = 16'h8305;
		repeat (3) @(negedge clk);
		cmp16(command_reply_word, `DRRR_WORD_RESET);
		cmp1(instruction_complete_flag, 1'b0);
		cmp16({8'h00, mon_item_code}, 16'h0005);
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		// frequency rows
		foreach (rows[r]) begin
			cyclic_profile_setting = rows[r].prof;
			frequency_command_word = rows[r].val;
			slow = r[0];
			if (rows[r].pers) frequency_write_trigger_persistent = 1'b1;
			else frequency_write_trigger_volatile = 1'b1;
			for (i = 0; i < 20 && freq_wr_req !== 1'b1; i++) @(negedge clk);
			cmp16(freq_wr_value, rows[r].val);
			cmp1(freq_wr_persistent, rows[r].pers);
			for (i = 0; i < 20 && freq_wr_done !== 1'b1; i++) @(negedge clk);
			repeat (2) @(negedge clk);
			cmp16(command_reply_word & rows[r].mask, rows[r].exp);
			frequency_write_trigger_volatile = 1'b0;
			frequency_write_trigger_persistent = 1'b0;
			repeat (2) @(negedge clk);
		end
		// monitor scan
		third_monitor_select_word = 16'h0010;
		fourth_monitor_select_word = 16'h0020;
		fifth_monitor_select_word = 16'h0090;
		sixth_monitor_select_word = 16'h0030;
		for (int n = 0; n < 2; n++) begin
			negative_monitor_display_setting = n[0];
			monitor_trigger_bit = 1'b1;
			repeat (10) @(negedge clk);
			cmp16(first_monitor_word, exp_mon(8'h05, n[0]));
			cmp16(second_monitor_or_frequency_word, exp_mon(8'h83, n[0]));
			cmp16(third_monitor_word, exp_mon(8'h10, n[0]));
			cmp16(fourth_monitor_word, exp_mon(8'h20, n[0]));
			cmp16(fifth_monitor_word, exp_mon(8'h90, n[0]));
			cmp16(sixth_monitor_word, exp_mon(8'h30, n[0]));
			monitor_trigger_bit = 1'b0;
			@(negedge clk);
		end
		monitor_select_word = 16'h0005;
		output_frequency = 16'h0bb8;
		repeat (2) @(negedge clk);
		cmp16(second_monitor_or_frequency_word, 16'h0bb8);
		// fault record lookup
		fault_record_select_word = 16'h0003;
		repeat (2) @(negedge clk);
		cmp16(fault_record_data_word, 16'h0359);
		cmp16(fault_record_frequency_word, 16'h0311);
		cmp16(fault_record_current_word, 16'h0322);
		cmp16(fault_record_voltage_word, 16'h0333);
		cmp16(fault_record_on_time_word, 16'h4403);
		// instruction run
		first_instruction_word = 16'h0f01;
		extended_instruction_words = {16'h0400, 16'h0300, 16'h0080, 16'h0f00, `DRRR_INSTR_DISABLED};
		extended_instruction_data = {16'h0001, 16'h1234, 16'h0000, 16'h0000, 16'h0000};
		network_mode = 1'b1;
		drive_stopped = 1'b0;
		req_seen = 0;
		instruction_execute_trigger = 1'b1;
		for (i = 0; i < 200 && instruction_complete_flag !== 1'b1; i++) @(negedge clk);
		cmp1(instruction_complete_flag, 1'b1);
		cmp16(req_seen, 16'h0004);
		cmp16(command_reply_word, 16'h0203);
		cmp16(instruction_read_data_word, 16'h0000);
		for (int w = 0; w < `DRRR_EXT_WORDS; w++) cmp16(extended_reply_and_data_words[w*16 +: 16], exp_ext[w]);
		instruction_execute_trigger = 1'b0;
		repeat (2) @(negedge clk);
		cmp1(instruction_complete_flag, 1'b0);
		report_and_stop;
	end
endmodule
